/* core/sfp_buf2.sv */
`timescale 1ns/1ps
// two-entry buffer, every output straight from a flop
module sfp_buf2 #(
  parameter int unsigned WIDTH = 8
) (
  input  wire logic             i_clk_sys,
  input  wire logic             i_rst,
  input  wire logic             i_in_valid,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_in_ready,
  output logic                  o_out_valid,
  output logic [WIDTH-1:0]      o_out_data,
  input  wire logic             i_out_ready
);

  logic [WIDTH-1:0] head_reg, head_next;   // word presented to the drain
  logic             head_v_reg, head_v_next;
  logic [WIDTH-1:0] tail_reg, tail_next;   // second word, kept on stall
  logic             tail_v_reg, tail_v_next;
  logic             ready_reg, ready_next;
  logic             push;
  logic             pop;

  // next values: push only while the tail is free
  always_comb begin
    push        = i_in_valid & ready_reg;
    pop         = head_v_reg & i_out_ready;
    head_next   = head_reg;
    head_v_next = head_v_reg;
    tail_next   = tail_reg;
    tail_v_next = tail_v_reg;
    if (pop) begin
      // promote tail, else take the incoming word
      if (tail_v_reg) begin
        head_next   = tail_reg;
        tail_v_next = 1'b0;
      end else begin
        head_next   = i_in_data;
        head_v_next = push;
      end
    end else if (push) begin
      if (!head_v_reg) begin
        head_next   = i_in_data;
        head_v_next = 1'b1;
      end else begin
        tail_next   = i_in_data;
        tail_v_next = 1'b1;
      end
    end
    ready_next = ~tail_v_next;
  end

  // registers
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      head_reg   <= '0;
      head_v_reg <= 1'b0;
      tail_reg   <= '0;
      tail_v_reg <= 1'b0;
      ready_reg  <= 1'b1;
    end else begin
      head_reg   <= head_next;
      head_v_reg <= head_v_next;
      tail_reg   <= tail_next;
      tail_v_reg <= tail_v_next;
      ready_reg  <= ready_next;
    end
  end

  assign o_in_ready  = ready_reg;
  assign o_out_valid = head_v_reg;
  assign o_out_data  = head_reg;

endmodule

/* core/sfp_pin_if.sv */
`timescale 1ns/1ps
// Contract
// - capture input bits on serial clock rise
// - change driven read data on clock fall
// - deselected means primary output high impedance
// - deselected drops to standby unless busy
// - select low gives active power state
// - single transfers take bits from line zero
// - fast reads turn line one bidirectional
// - dual/quad programs sample line one
// - dual protocol uses lines zero, one
// - supply-run in quad falls back single
// - line two bidirectional in quad transfers
// - receivers live unless line driven
// - quad line three ignores pause, reset
// - reset pin low forces reset, hi-z
// - pause freezes clock, line one hi-z
// - pause disabled by config bit four
module sfp_pin_if
  import sfp_pkg::*;
(
  input  wire logic        i_clk_sys,
  input  wire logic        i_rst,
  input  wire logic        i_sclk,
  input  wire logic        i_cs_n,
  input  wire logic [3:0]  i_dq,
  input  wire logic        i_reset_n,
  input  wire logic        i_vpp_high,
  output logic [3:0]       o_dq,
  output logic [3:0]       o_dq_oe_n,
  input  wire logic [1:0]  i_protocol,
  input  wire logic [1:0]  i_width,
  input  wire logic        i_dir_out,
  input  wire logic        i_busy,
  input  wire logic [7:0]  i_nvcfg,
  input  wire logic [7:0]  i_vecfg,
  output logic             o_rx_valid,
  output logic [7:0]       o_rx_data,
  input  wire logic        i_rx_ready,
  output logic             o_rx_overrun,
  input  wire logic        i_tx_valid,
  input  wire logic [7:0]  i_tx_data,
  output logic             o_tx_ready,
  output logic             o_standby,
  output logic             o_active,
  output logic             o_hold
);

  // step in bits for one clock edge
  function automatic logic [3:0] width_step(input sfp_width_t w);
    unique case (w)
      SFP_W1: width_step = 4'h1;
      SFP_W2: width_step = 4'h2;
      SFP_W4: width_step = 4'h4;
      default: width_step = 4'h1;
    endcase
  endfunction

  // shift lanes in below the byte, upper line taken as the higher bit
  function automatic logic [7:0] shift_in(input logic [7:0] sh, input logic [3:0] ln, input sfp_width_t w);
    unique case (w)
      SFP_W1: shift_in = {sh[6:0], ln[0]};
      SFP_W2: shift_in = {sh[5:0], ln[1:0]};
      SFP_W4: shift_in = {sh[3:0], ln[3:0]};
      default: shift_in = sh;
    endcase
  endfunction

  // top bits of the byte placed on the lanes
  function automatic logic [3:0] lanes_out(input logic [7:0] sh, input sfp_width_t w);
    unique case (w)
      SFP_W1: lanes_out = {2'h0, sh[7], 1'h0};
      SFP_W2: lanes_out = {2'h0, sh[7:6]};
      SFP_W4: lanes_out = sh[7:4];
      default: lanes_out = 4'h0;
    endcase
  endfunction

  // synchroniser stages; stage one is read only by stage two
  logic [SYNC_W-1:0] s1_reg;
  logic [SYNC_W-1:0] s2_reg;
  logic [SYNC_W-1:0] s3_reg;

  // two-flop crossing plus one delay stage for edge finding
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      s1_reg <= SYNC_RST;
      s2_reg <= SYNC_RST;
      s3_reg <= SYNC_RST;
    end else begin
      s1_reg <= {i_vpp_high, i_reset_n, i_cs_n, i_sclk, i_dq};
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  logic       sclk_rise;   // serial clock rising edge seen
  logic       sclk_fall;   // serial clock falling edge seen
  logic       cs_fall;     // select high-to-low edge seen
  logic       cs_n_s;      // synchronised select
  logic       rst_n_s;     // synchronised hardware reset
  logic       vpp_s;       // synchronised enhanced supply
  logic [3:0] dq_s;        // synchronised data lines
  sfp_width_t eff_width;   // lane width actually used
  logic       quad_lines;  // lines two and three carry data
  logic       hold_en;     // pause function armed
  logic       hold_req;    // pause requested on line three

  // pin decode and protocol resolution
  always_comb begin
    sclk_rise = s2_reg[IDX_SCLK] & ~s3_reg[IDX_SCLK];
    sclk_fall = ~s2_reg[IDX_SCLK] & s3_reg[IDX_SCLK];
    cs_n_s    = s2_reg[IDX_CS_N];
    cs_fall   = ~s2_reg[IDX_CS_N] & s3_reg[IDX_CS_N];
    rst_n_s   = s2_reg[IDX_RESET_N];
    vpp_s     = s2_reg[IDX_VPP];
    dq_s      = s2_reg[IDX_DQ3:IDX_DQ0];
    unique case (sfp_proto_t'(i_protocol))
      SFP_PROTO_DUAL: eff_width = SFP_W2;
      SFP_PROTO_QUAD: eff_width = vpp_s ? SFP_W1 : SFP_W4;
      SFP_PROTO_EXT:  eff_width = (i_width == 2'h2) ? SFP_W4 : ((i_width == 2'h1) ? SFP_W2 : SFP_W1);
      default:        eff_width = SFP_W1;
    endcase
    quad_lines = (eff_width == SFP_W4);
    hold_en    = i_nvcfg[HOLD_EN_BIT] & i_vecfg[HOLD_EN_BIT];
    hold_req   = hold_en & ~quad_lines & ~dq_s[IDX_DQ3];
  end

  sfp_state_t state_reg, state_next;  // link state
  logic       standby_reg, standby_next;
  logic       active_reg, active_next;
  logic       hold_reg, hold_next;

  // link state machine
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      SFP_ST_RESET: begin
        if (rst_n_s) begin
          state_next = SFP_ST_IDLE;
        end
      end
      SFP_ST_IDLE: begin
        // only a select fall opens traffic
        if (cs_fall) begin
          state_next = SFP_ST_SEL;
        end
      end
      SFP_ST_SEL: begin
        if (cs_n_s) begin
          state_next = SFP_ST_IDLE;
        end else if (hold_req) begin
          state_next = SFP_ST_HOLD;
        end
      end
      SFP_ST_HOLD: begin
        if (cs_n_s) begin
          state_next = SFP_ST_IDLE;
        end else if (!hold_req) begin
          state_next = SFP_ST_SEL;
        end
      end
    endcase
    if (!rst_n_s) begin
      state_next = SFP_ST_RESET;
    end
    // standby only when no internal cycle
    standby_next = (state_next == SFP_ST_IDLE || state_next == SFP_ST_RESET) & ~i_busy;
    active_next  = (state_next == SFP_ST_SEL || state_next == SFP_ST_HOLD);
    hold_next    = (state_next == SFP_ST_HOLD);
  end

  // link state registers
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      state_reg   <= SFP_ST_RESET;
      standby_reg <= 1'b0;
      active_reg  <= 1'b0;
      hold_reg    <= 1'b0;
    end else begin
      state_reg   <= state_next;
      standby_reg <= standby_next;
      active_reg  <= active_next;
      hold_reg    <= hold_next;
    end
  end

  logic       live;                      // selected and not paused
  logic [7:0] rx_sh_reg, rx_sh_next;     // incoming byte
  logic [3:0] rx_cnt_reg, rx_cnt_next;   // bits collected
  logic       push_reg, push_next;       // byte into buffer
  logic [7:0] push_d_reg, push_d_next;
  logic       ovr_reg, ovr_next;         // byte lost on full buffer
  logic       buf_ready;                 // buffer can take a byte
  logic [3:0] rx_sum;

  // receive path
  always_comb begin
    live        = (state_reg == SFP_ST_SEL);
    rx_sh_next  = rx_sh_reg;
    rx_cnt_next = rx_cnt_reg;
    push_next   = 1'b0;
    push_d_next = push_d_reg;
    ovr_next    = ovr_reg;
    rx_sum      = rx_cnt_reg + width_step(eff_width);
    if (!active_reg) begin
      rx_cnt_next = 4'h0;
    end
    if (live && sclk_rise && !i_dir_out) begin
      // line zero; line one added for wide programs
      // earliest bits end up on top
      rx_sh_next = shift_in(rx_sh_reg, dq_s, eff_width);
      if (rx_sum >= BYTE_BITS) begin
        rx_cnt_next = 4'h0;
        push_next   = 1'b1;
        push_d_next = rx_sh_next;
      end else begin
        rx_cnt_next = rx_sum;
      end
    end
    // lost byte wins over the clear at select
    if (push_reg && !buf_ready) begin
      ovr_next = 1'b1;
    end else if (state_reg == SFP_ST_IDLE && cs_fall) begin
      ovr_next = 1'b0;
    end
  end

  // receive registers
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      rx_sh_reg  <= 8'h00;
      rx_cnt_reg <= 4'h0;
      push_reg   <= 1'b0;
      push_d_reg <= 8'h00;
      ovr_reg    <= 1'b0;
    end else begin
      rx_sh_reg  <= rx_sh_next;
      rx_cnt_reg <= rx_cnt_next;
      push_reg   <= push_next;
      push_d_reg <= push_d_next;
      ovr_reg    <= ovr_next;
    end
  end

  // buffer between the link and the byte consumer
  sfp_buf2 #(
    .WIDTH (BYTE_W)
  ) u_rx_buf (
    .i_clk_sys   (i_clk_sys),
    .i_rst       (i_rst),
    .i_in_valid  (push_reg),
    .i_in_data   (push_d_reg),
    .o_in_ready  (buf_ready),
    .o_out_valid (o_rx_valid),
    .o_out_data  (o_rx_data),
    .i_out_ready (i_rx_ready)
  );

  logic [7:0] hold_b_reg, hold_b_next;   // next byte to send
  logic       hold_f_reg, hold_f_next;   // next byte present
  logic [7:0] tx_sh_reg, tx_sh_next;     // byte being sent
  logic [3:0] tx_cnt_reg, tx_cnt_next;   // bits left in shifter
  logic [3:0] dq_reg, dq_next;
  logic [3:0] oe_n_reg, oe_n_next;
  logic       tx_rdy_reg, tx_rdy_next;
  logic [7:0] load_b;
  logic [3:0] step;

  // transmit path
  always_comb begin
    hold_b_next = hold_b_reg;
    hold_f_next = hold_f_reg;
    tx_sh_next  = tx_sh_reg;
    tx_cnt_next = tx_cnt_reg;
    dq_next     = dq_reg;
    oe_n_next   = oe_n_reg;
    step        = width_step(eff_width);
    load_b      = hold_f_reg ? hold_b_reg : TX_IDLE_BYTE;
    if (i_tx_valid && tx_rdy_reg) begin
      hold_b_next = i_tx_data;
      hold_f_next = 1'b1;
    end
    // drive new bits on the falling edge
    // line one turns output for fast reads
    if (live && sclk_fall && i_dir_out) begin
      if (tx_cnt_reg == 4'h0) begin
        dq_next     = lanes_out(load_b, eff_width);
        tx_sh_next  = load_b << step;
        tx_cnt_next = BYTE_BITS - step;
        hold_f_next = (i_tx_valid && tx_rdy_reg);
      end else begin
        dq_next     = lanes_out(tx_sh_reg, eff_width);
        tx_sh_next  = tx_sh_reg << step;
        tx_cnt_next = tx_cnt_reg - step;
      end
      unique case (eff_width)
        SFP_W1: oe_n_next = OE_W1;
        SFP_W2: oe_n_next = OE_W2;
        SFP_W4: oe_n_next = OE_W4;
        default: oe_n_next = OE_ALL_OFF;
      endcase
    end
    if (!live || !i_dir_out) begin
      oe_n_next   = OE_ALL_OFF;
      tx_cnt_next = active_reg ? tx_cnt_reg : 4'h0;
    end
    tx_rdy_next = ~hold_f_next;
  end

  // transmit registers
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      hold_b_reg <= 8'h00;
      hold_f_reg <= 1'b0;
      tx_sh_reg  <= 8'h00;
      tx_cnt_reg <= 4'h0;
      dq_reg     <= 4'h0;
      oe_n_reg   <= OE_ALL_OFF;
      tx_rdy_reg <= 1'b0;
    end else begin
      hold_b_reg <= hold_b_next;
      hold_f_reg <= hold_f_next;
      tx_sh_reg  <= tx_sh_next;
      tx_cnt_reg <= tx_cnt_next;
      dq_reg     <= dq_next;
      oe_n_reg   <= oe_n_next;
      tx_rdy_reg <= tx_rdy_next;
    end
  end

  assign o_dq         = dq_reg;
  assign o_dq_oe_n    = oe_n_reg;
  assign o_tx_ready   = tx_rdy_reg;
  assign o_rx_overrun = ovr_reg;
  assign o_standby    = standby_reg;
  assign o_active     = active_reg;
  assign o_hold       = hold_reg;

  a_push_after_rise: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    $rose(push_reg) |-> $past(sclk_rise)) else $error("byte pushed without clock rise");
  a_dq_on_fall: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    $changed(dq_reg) |-> $past(sclk_fall)) else $error("data line changed off falling edge");
  a_desel_hiz: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (state_reg == SFP_ST_IDLE) |=> (oe_n_reg == OE_ALL_OFF)) else $error("driving while deselected");
  a_standby_idle: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (state_reg == SFP_ST_IDLE && $past(state_reg) == SFP_ST_IDLE && !$past(i_busy)) |-> standby_reg)
    else $error("no standby while idle");
  a_select_active: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (state_reg == SFP_ST_IDLE && cs_fall && rst_n_s) |=> active_reg ##1 (state_reg != SFP_ST_RESET))
    else $error("select fall not active");
  a_vpp_single: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (i_protocol == 2'h2 && vpp_s) |-> (step == 4'h1)) else $error("supply run kept quad lanes");
  a_rx_gated: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (i_dir_out && $past(i_dir_out)) |=> !$rose(push_reg)) else $error("sampled while driving");
  a_quad_no_hold: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (state_reg == SFP_ST_SEL && quad_lines && !cs_n_s && rst_n_s) |=> (state_reg != SFP_ST_HOLD))
    else $error("pause taken in quad");
  a_reset_hiz: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    !rst_n_s |=> (state_reg == SFP_ST_RESET) ##1 (oe_n_reg == OE_ALL_OFF)) else $error("reset pin not obeyed");
  a_hold_dq1_hiz: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (state_reg == SFP_ST_HOLD) |=> oe_n_reg[IDX_DQ1]) else $error("line one driven in pause");
  a_hold_cfg_off: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (state_reg == SFP_ST_SEL && !(i_nvcfg[HOLD_EN_BIT] && i_vecfg[HOLD_EN_BIT])) |=> (state_reg != SFP_ST_HOLD))
    else $error("pause taken while disabled");

endmodule

/* core/sfp_pkg.sv */
package sfp_pkg;

  // lane width of one serial clock edge
  typedef enum logic [1:0] {
    SFP_W1,
    SFP_W2,
    SFP_W4
  } sfp_width_t;

  // bus protocol chosen by the configuration logic
  typedef enum logic [1:0] {
    SFP_PROTO_EXT,
    SFP_PROTO_DUAL,
    SFP_PROTO_QUAD
  } sfp_proto_t;

  // link state as seen from the select and reset pins
  typedef enum logic [1:0] {
    SFP_ST_RESET,
    SFP_ST_IDLE,
    SFP_ST_SEL,
    SFP_ST_HOLD
  } sfp_state_t;

  // positions inside the synchroniser vector
  localparam int unsigned SYNC_W      = 8;
  localparam int unsigned IDX_DQ0     = 0;
  localparam int unsigned IDX_DQ1     = 1;
  localparam int unsigned IDX_DQ2     = 2;
  localparam int unsigned IDX_DQ3     = 3;
  localparam int unsigned IDX_SCLK    = 4;
  localparam int unsigned IDX_CS_N    = 5;
  localparam int unsigned IDX_RESET_N = 6;
  localparam int unsigned IDX_VPP     = 7;

  // pause enable bit in both configuration registers
  localparam int unsigned HOLD_EN_BIT = 4;

  // byte geometry and fill values
  localparam int unsigned BYTE_W      = 8;
  localparam logic [3:0]  BYTE_BITS   = 4'h8;
  localparam logic [7:0]  TX_IDLE_BYTE = 8'hFF;
  localparam logic [3:0]  OE_ALL_OFF  = 4'hF;
  localparam logic [3:0]  OE_W1       = 4'hD;
  localparam logic [3:0]  OE_W2       = 4'hC;
  localparam logic [3:0]  OE_W4       = 4'h0;
  // select, reset pin and serial clock all idle high, so no false edge after reset
  localparam logic [SYNC_W-1:0] SYNC_RST = 8'h70;

endpackage

/* verif/sfp_host_model.sv */
`timescale 1ns/1ps
// host controller model: select, serial clock, data lanes and reset pin
module sfp_host_model (
  input  wire logic       i_clk_sys,
  input  wire logic [3:0] i_dq,
  input  wire logic [3:0] i_dq_oe_n,
  output logic            o_sclk,
  output logic            o_cs_n,
  output logic            o_reset_n,
  output logic [3:0]      o_wire
);
  logic [3:0] drv_en;   // lanes the host drives
  logic [3:0] drv_val;  // host lane values
  logic       flip;     // moving filler on floating lanes
  logic       pause_on; // pulls lane three low
  logic       glitch;   // read data moved while clock high
  initial begin
    o_sclk = 1'b1;
    o_cs_n = 1'b1;
    o_reset_n = 1'b1;
    drv_en = 4'h0;
    drv_val = 4'h0;
    flip = 1'b0;
    pause_on = 1'b0;
    glitch = 1'b0;
  end
  // floating lanes zero to two toggle so a stale value never reads back
  always @(posedge i_clk_sys) begin
    flip <= ~flip;
  end
  // wire level from both parties' enables; lane three idles high on its pull-up
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      o_wire[i] = !i_dq_oe_n[i] ? i_dq[i] : (drv_en[i] ? drv_val[i] : ((i == 3) ? 1'b1 : flip));
    end
    if (pause_on) begin
      o_wire[3] = 1'b0;
    end
  end
  // wait n edges, then step just past the edge
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk_sys);
    #1;
  endtask
  task automatic select();
    o_cs_n = 1'b0;
    cyc(8);
  endtask
  task automatic deselect();
    o_cs_n = 1'b1;
    drv_en = 4'h0;
    cyc(8);
  endtask
  task automatic pin_reset(input logic v);
    o_reset_n = v;
  endtask
  // lanes read back; single read comes on line one
  function automatic logic [3:0] lanes(input int w, input logic rd);
    return (rd && w == 1) ? {3'h0, o_wire[1]} : o_wire & 4'((1 << w) - 1);
  endfunction
  task automatic xfer(input int w, input logic rd, input logic [7:0] b, output logic [7:0] r);
    logic [7:0] t;
    logic [3:0] s;
    r = 8'h00;
    for (int k = 0; k < 8 / w; k++) begin
      o_sclk = 1'b0;
      t = b << (w * k);
      drv_val = 4'(t >> (8 - w));
      drv_en = rd ? 4'h0 : 4'((1 << w) - 1);
      cyc(8);
      s = lanes(w, rd);
      r = 8'((r << w) | s);
      o_sclk = 1'b1;
      cyc(7);
      if (rd && lanes(w, rd) !== s) begin
        glitch = 1'b1;
      end
      cyc(1);
    end
  endtask
endmodule

/* verif/test_serial_flash_pin_interface.sv */
`timescale 1ns/1ps
// bench for the flash pin interface, host model on the far side
module test_serial_flash_pin_interface;
  import sfp_pkg::*;
  logic       i_clk_sys, i_rst, i_vpp_high, i_dir_out, i_busy;
  logic [1:0] i_protocol, i_width;
  logic [7:0] i_nvcfg, i_vecfg, i_tx_data, r;
  logic       i_rx_ready, i_tx_valid;
  logic       sclk, cs_n, reset_n, o_rx_valid, o_rx_overrun, o_tx_ready, o_standby, o_active, o_hold;
  logic [3:0] dq_wire, o_dq, o_dq_oe_n;
  logic [7:0] o_rx_data;
  int         fails, checks_done;
  sfp_host_model u_host (.i_clk_sys(i_clk_sys), .i_dq(o_dq), .i_dq_oe_n(o_dq_oe_n), .o_sclk(sclk),
    .o_cs_n(cs_n), .o_reset_n(reset_n), .o_wire(dq_wire));
  sfp_pin_if u_dut (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_sclk(sclk), .i_cs_n(cs_n), .i_dq(dq_wire),
    .i_reset_n(reset_n), .i_vpp_high(i_vpp_high), .o_dq(o_dq), .o_dq_oe_n(o_dq_oe_n),
    .i_protocol(i_protocol), .i_width(i_width), .i_dir_out(i_dir_out), .i_busy(i_busy),
    .i_nvcfg(i_nvcfg), .i_vecfg(i_vecfg), .o_rx_valid(o_rx_valid), .o_rx_data(o_rx_data),
    .i_rx_ready(i_rx_ready), .o_rx_overrun(o_rx_overrun), .i_tx_valid(i_tx_valid), .i_tx_data(i_tx_data),
    .o_tx_ready(o_tx_ready), .o_standby(o_standby), .o_active(o_active), .o_hold(o_hold));
  // 200 MHz system clock
  initial begin
    i_clk_sys = 1'b0;
    forever #2.5 i_clk_sys = ~i_clk_sys;
  end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask
  // bounded wait for a byte, then take it
  task automatic get_rx(input logic [7:0] exp);
    for (int n = 0; n < 200 && o_rx_valid !== 1'b1; n++) begin
      u_host.cyc(1);
    end
    if (o_rx_valid !== 1'b1) begin
      fails++;
      report_and_stop();
    end
    chk("rx_data", exp, o_rx_data);
    i_rx_ready = 1'b1;
    u_host.cyc(1);
    i_rx_ready = 1'b0;
    u_host.cyc(1);
  endtask
  task automatic put_tx(input logic [7:0] b);
    for (int n = 0; n < 200 && o_tx_ready !== 1'b1; n++) begin
      u_host.cyc(1);
    end
    if (o_tx_ready !== 1'b1) begin
      fails++;
      report_and_stop();
    end
    i_tx_valid = 1'b1;
    i_tx_data = b;
    u_host.cyc(1);
    i_tx_valid = 1'b0;
  endtask
  task automatic t_idle();
    chk("oe_n", 8'h0F, 8'(o_dq_oe_n));
    chk("standby", 8'h01, 8'(o_standby));
    i_busy = 1'b1;
    u_host.cyc(4);
    chk("standby busy", 8'h00, 8'(o_standby));
    i_busy = 1'b0;
    u_host.cyc(4);
    $display("idle test done");
  endtask
  // receive in every lane layout
  task automatic t_rx();
    logic [1:0] pr [5] = '{2'd0, 2'd0, 2'd0, 2'd1, 2'd2};
    logic [1:0] wd [5] = '{2'd0, 2'd1, 2'd2, 2'd0, 2'd0};
    int         ln [5] = '{1, 2, 4, 2, 4};
    logic [7:0] bt [5] = '{8'hA5, 8'h69, 8'h5E, 8'h1E, 8'hC3};
    for (int i = 0; i < 5; i++) begin
      i_protocol = pr[i];
      i_width = wd[i];
      u_host.select();
      chk("active", 8'h01, 8'(o_active));
      chk("standby sel", 8'h00, 8'(o_standby));
      u_host.xfer(ln[i], 1'b0, bt[i], r);
      get_rx(bt[i]);
      u_host.deselect();
    end
    $display("receive test done");
  endtask
  task automatic t_tx();
    i_protocol = 2'd0;
    i_width = 2'd0;
    i_dir_out = 1'b1;
    put_tx(8'h3C);
    u_host.select();
    u_host.xfer(1, 1'b1, 8'h00, r);
    chk("tx byte w1", 8'h3C, r);
    chk("oe_n w1", 8'h0D, 8'(o_dq_oe_n));
    u_host.xfer(1, 1'b1, 8'h00, r);
    chk("tx underrun", 8'hFF, r);
    u_host.deselect();
    chk("oe_n desel", 8'h0F, 8'(o_dq_oe_n));
    i_protocol = 2'd2;
    put_tx(8'h96);
    u_host.select();
    u_host.xfer(4, 1'b1, 8'h00, r);
    chk("tx byte w4", 8'h96, r);
    chk("oe_n w4", 8'h00, 8'(o_dq_oe_n));
    chk("read glitch", 8'h00, 8'(u_host.glitch));
    u_host.deselect();
    i_protocol = 2'd1;
    put_tx(8'hC6);
    u_host.select();
    u_host.xfer(2, 1'b1, 8'h00, r);
    chk("tx byte w2", 8'hC6, r);
    chk("oe_n w2", 8'h0C, 8'(o_dq_oe_n));
    u_host.deselect();
    i_dir_out = 1'b0;
    $display("transmit test done");
  endtask
  // stalled consumer: third byte is lost and flagged
  task automatic t_buffer();
    i_protocol = 2'd0;
    u_host.select();
    for (int i = 0; i < 3; i++) begin
      u_host.xfer(1, 1'b0, 8'(8'h41 + i), r);
    end
    u_host.cyc(8);
    chk("overrun", 8'h01, 8'(o_rx_overrun));
    get_rx(8'h41);
    get_rx(8'h42);
    u_host.cyc(4);
    chk("rx empty", 8'h00, 8'(o_rx_valid));
    u_host.deselect();
    u_host.select();
    chk("overrun clr", 8'h00, 8'(o_rx_overrun));
    u_host.deselect();
    $display("buffer test done");
  endtask
  task automatic pause_try(input logic [1:0] pr, input logic [7:0] nv, input logic [7:0] vc, input logic [7:0] exp);
    i_protocol = pr;
    i_nvcfg = nv;
    i_vecfg = vc;
    u_host.select();
    u_host.pause_on = 1'b1;
    u_host.cyc(8);
    chk("hold", exp, 8'(o_hold));
    chk("active hold", 8'h01, 8'(o_active));
  endtask
  task automatic t_pause();
    pause_try(2'd0, 8'h10, 8'h10, 8'h01);
    u_host.xfer(1, 1'b0, 8'hA5, r);
    u_host.pause_on = 1'b0;
    u_host.cyc(8);
    u_host.xfer(1, 1'b0, 8'h3C, r);
    get_rx(8'h3C);
    u_host.deselect();
    pause_try(2'd0, 8'h10, 8'h00, 8'h00);
    u_host.pause_on = 1'b0;
    u_host.deselect();
    pause_try(2'd0, 8'h00, 8'h10, 8'h00);
    u_host.pause_on = 1'b0;
    u_host.deselect();
    pause_try(2'd2, 8'h10, 8'h10, 8'h00);
    u_host.pause_on = 1'b0;
    u_host.deselect();
    i_nvcfg = 8'h00;
    i_vecfg = 8'h00;
    $display("pause test done");
  endtask
  task automatic t_vpp();
    i_protocol = 2'd2;
    i_vpp_high = 1'b1;
    u_host.select();
    u_host.xfer(1, 1'b0, 8'h5A, r);
    get_rx(8'h5A);
    u_host.deselect();
    i_vpp_high = 1'b0;
    u_host.select();
    u_host.xfer(4, 1'b0, 8'hB4, r);
    get_rx(8'hB4);
    u_host.deselect();
    $display("supply test done");
  endtask
  task automatic t_pinrst();
    i_protocol = 2'd0;
    i_dir_out = 1'b1;
    u_host.select();
    u_host.xfer(1, 1'b1, 8'h00, r);
    // reset pin pulsed only while no internal write
    u_host.pin_reset(1'b0);
    u_host.cyc(6);
    chk("active rst", 8'h00, 8'(o_active));
    chk("oe_n rst", 8'h0F, 8'(o_dq_oe_n));
    u_host.pin_reset(1'b1);
    u_host.deselect();
    chk("standby rst", 8'h01, 8'(o_standby));
    i_dir_out = 1'b0;
    $display("pin reset test done");
  endtask
  initial begin
    fails = 0;
    checks_done = 0;
    i_rst = 1'b1;
    {i_vpp_high, i_dir_out, i_busy, i_rx_ready, i_tx_valid} = 5'h00;
    {i_protocol, i_width} = 4'h0;
    {i_nvcfg, i_vecfg, i_tx_data} = 24'h000000;
    u_host.cyc(3);
    i_rst = 1'b0;
    u_host.cyc(8);
    t_idle();
    t_rx();
    t_tx();
    t_buffer();
    t_pause();
    t_vpp();
    t_pinrst();
    report_and_stop();
  end
endmodule
